// ---- src/rsa_pkg.sv ----
/*
 Shared constants for the rotate / subtract-with-borrow / special-page move datapath.
 Assumes a single 40 MHz clock domain and Avalon-MM register access.
*/
package rsa_pkg;
   localparam int unsigned CLK_PERIOD_NS = 25;
   // Register word offsets (byte addresses)
   localparam logic [5:0] OFS_CMD = 6'h00;
   localparam logic [5:0] OFS_ACC = 6'h04;
   localparam logic [5:0] OFS_STATUS = 6'h08;
   localparam logic [5:0] OFS_IMM = 6'h0c;
   localparam logic [5:0] OFS_SPR_BASE = 6'h10;
   localparam logic [5:0] OFS_REG_WIN = 6'h14;
   // Command word fields
   localparam int unsigned CMD_OP_LSB = 0;
   localparam int unsigned CMD_DEST_BIT = 2;
   localparam int unsigned CMD_RADDR_LSB = 8;
   localparam int unsigned CMD_SIDX_LSB = 16;
   // Status word fields
   localparam int unsigned ST_C = 0;
   localparam int unsigned ST_DC = 1;
   localparam int unsigned ST_Z = 2;
   localparam int unsigned ST_BUSY = 3;
   // Sizes
   localparam int unsigned REG_DEPTH = 64;
   localparam int unsigned SPR_DEPTH = 16;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [2:0] FLAGS_RST = 3'h0;
   typedef enum logic [1:0] {
      rsa_rotate_right_carry_op,
      rsa_subtract_borrow_register_op,
      rsa_subtract_borrow_immediate_op,
      rsa_special_page_read_op
   } rsa_op_e;
   typedef enum logic [1:0] {RSA_IDLE, RSA_EXEC, RSA_DONE} rsa_state_e;
endpackage

// ---- src/rsa_adder.sv ----
/*
 Eight-bit adder computing a + ~b + cin with nibble and full carry out.
 Assumes pure combinational use inside the datapath.
*/
module rsa_adder import rsa_pkg::*; (
   input wire logic [7:0] a, // Minuend
   input wire logic [7:0] b, // Subtrahend before inversion
   input wire logic cin, // Carry in, 1 means no borrow
   output logic [7:0] sum, // Result
   output logic dc_out, // Carry from bit 3 into bit 4
   output logic c_out // Carry from bit 7
);
   logic [4:0] lo;
   logic [4:0] hi;
   always_comb begin
      lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      hi = {1'b0, a[7:4]} + {1'b0, ~b[7:4]} + {4'h0, lo[4]};
      sum = {hi[3:0], lo[3:0]};
      dc_out = lo[4];
      c_out = hi[4];
   end
endmodule

// ---- src/rsa_alu.sv ----
/*
 Datapath for rotate-right-through-carry, subtract-with-borrow (register and
 immediate) and special-page read, with its register file and flags, reached
 over Avalon-MM. Assumes one clock mclk, async active-low reset rst_b.
*/
// What this block does
// - Rotate right through carry; only carry changes
// - Destination bit 0 to accumulator, 1 to register, for rotate and register subtract only
// - Register minus accumulator with carry; sets Z DC C
// - Carry set means no borrow; Z on zero
// - Immediate minus accumulator with carry into accumulator
// - Special page read into accumulator, flags kept
module rsa_alu import rsa_pkg::*; (
   input wire logic mclk, // Clock, 40 MHz
   input wire logic rst_b, // Async reset, active low
   input wire logic [5:0] address, // Byte address
   input wire logic read, // Read request
   input wire logic write, // Write request
   input wire logic [31:0] writedata, // Write data
   input wire logic [3:0] byteenable, // Byte lanes
   output logic [31:0] readdata, // Read data, registered
   output logic waitrequest, // Stall
   output logic [7:0] accumulator, // Accumulator value
   output logic carry_flag, // Carry
   output logic digit_carry_flag, // Digit carry
   output logic zero_flag // Zero
);
   logic [7:0] regs_q [REG_DEPTH];
   logic [7:0] spr_q [SPR_DEPTH];
   logic [7:0] acc_q, acc_d, imm_q, imm_d;
   logic c_q, c_d, dc_q, dc_d, z_q, z_d;
   logic [1:0] op_q, op_d;
   logic dest_q, dest_d;
   logic [5:0] raddr_q, raddr_d, win_q, win_d;
   logic [3:0] sidx_q, sidx_d;
   logic [31:0] rdata_q, rdata_d;
   logic ack_q, ack_d;
   rsa_state_e st_q, st_d;
   logic [7:0] a_in, sum, rot, res;
   logic dc_o, c_o, reg_we, spr_we;
   logic [7:0] reg_wdata;
   logic [5:0] reg_waddr;

   // Only the low lane carries an 8-bit register
   function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
      byte_merge = be[0] ? wd[7:0] : old;
   endfunction

   wire logic req = read | write;
   assign waitrequest = req & ~ack_q; // Every access takes one wait cycle
   assign readdata = rdata_q;
   assign accumulator = acc_q;
   assign carry_flag = c_q;
   assign digit_carry_flag = dc_q;
   assign zero_flag = z_q;

   assign a_in = (op_q == rsa_subtract_borrow_immediate_op) ? imm_q : regs_q[raddr_q];
   rsa_adder u_add (
      .a(a_in),
      .b(acc_q),
      .cin(c_q),
      .sum(sum),
      .dc_out(dc_o),
      .c_out(c_o)
   );
   assign rot = {c_q, regs_q[raddr_q][7:1]};

   always_comb begin
      acc_d = acc_q;
      imm_d = imm_q;
      c_d = c_q;
      dc_d = dc_q;
      z_d = z_q;
      op_d = op_q;
      dest_d = dest_q;
      raddr_d = raddr_q;
      sidx_d = sidx_q;
      win_d = win_q;
      rdata_d = rdata_q;
      ack_d = 1'b0;
      st_d = st_q;
      reg_we = 1'b0;
      spr_we = 1'b0;
      res = sum;
      reg_wdata = 8'h00;
      reg_waddr = raddr_q;
      case (st_q)
         RSA_EXEC: begin
            st_d = RSA_IDLE;
            case (op_q)
               rsa_rotate_right_carry_op: begin
                  res = rot;
                  c_d = regs_q[raddr_q][0];
               end
               rsa_special_page_read_op: begin
                  res = spr_q[sidx_q];
               end
               default: begin
                  c_d = c_o;
                  dc_d = dc_o;
                  z_d = (sum == 8'h00);
               end
            endcase
            if (op_q == rsa_subtract_borrow_immediate_op || op_q == rsa_special_page_read_op || !dest_q) begin
               acc_d = res;
            end else begin
               reg_we = 1'b1;
               reg_wdata = res;
            end
         end
         default: begin
            st_d = RSA_IDLE;
            if (req && !ack_q) begin
               ack_d = 1'b1;
               if (write) begin
                  case (address)
                     OFS_CMD: if (byteenable[0]) begin
                        op_d = writedata[CMD_OP_LSB +: 2];
                        dest_d = writedata[CMD_DEST_BIT];
                        if (byteenable[1]) raddr_d = writedata[CMD_RADDR_LSB +: 6];
                        if (byteenable[2]) sidx_d = writedata[CMD_SIDX_LSB +: 4];
                        st_d = RSA_EXEC;
                     end
                     OFS_ACC: acc_d = byte_merge(acc_q, writedata, byteenable);
                     OFS_STATUS: if (byteenable[0]) begin
                        c_d = writedata[ST_C];
                        dc_d = writedata[ST_DC];
                        z_d = writedata[ST_Z];
                     end
                     OFS_IMM: imm_d = byte_merge(imm_q, writedata, byteenable);
                     OFS_SPR_BASE: begin
                        if (byteenable[0]) win_d = writedata[5:0];
                        spr_we = byteenable[1];
                     end
                     OFS_REG_WIN: begin
                        reg_we = byteenable[0];
                        reg_waddr = win_q;
                        reg_wdata = writedata[7:0];
                     end
                     default: ;
                  endcase
               end else begin
                  case (address)
                     OFS_ACC: rdata_d = {24'h0, acc_q};
                     OFS_STATUS: rdata_d = {28'h0, st_q != RSA_IDLE, z_q, dc_q, c_q};
                     OFS_IMM: rdata_d = {24'h0, imm_q};
                     OFS_SPR_BASE: rdata_d = {16'h0, spr_q[win_q[3:0]], 2'h0, win_q};
                     OFS_REG_WIN: rdata_d = {24'h0, regs_q[win_q]};
                     OFS_CMD: rdata_d = {12'h0, sidx_q, 2'h0, raddr_q, 5'h0, dest_q, op_q};
                     default: rdata_d = 32'h0;
                  endcase
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         acc_q <= ACC_RST;
         imm_q <= 8'h00;
         {z_q, dc_q, c_q} <= FLAGS_RST;
         op_q <= 2'h0;
         dest_q <= 1'b0;
         raddr_q <= 6'h00;
         sidx_q <= 4'h0;
         win_q <= 6'h00;
         rdata_q <= 32'h0;
         ack_q <= 1'b0;
         st_q <= RSA_IDLE;
      end else begin
         acc_q <= acc_d;
         imm_q <= imm_d;
         c_q <= c_d;
         dc_q <= dc_d;
         z_q <= z_d;
         op_q <= op_d;
         dest_q <= dest_d;
         raddr_q <= raddr_d;
         sidx_q <= sidx_d;
         win_q <= win_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
         st_q <= st_d;
      end
   end

   // Arrays have no reset, contents are software-defined
   always_ff @(posedge mclk) begin
      if (reg_we) regs_q[reg_waddr] <= reg_wdata;
      if (spr_we) spr_q[win_q[3:0]] <= writedata[15:8];
   end

   wire logic ex = (st_q == RSA_EXEC);
   wire logic sub_op = ex && (op_q == rsa_subtract_borrow_register_op || op_q == rsa_subtract_borrow_immediate_op);
   rotate_carry_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ex && op_q == rsa_rotate_right_carry_op |=> c_q == $past(regs_q[raddr_q][0])
      && z_q == $past(z_q) && dc_q == $past(dc_q)) else $error("rotate flags wrong");
   // Expected rotate built from the operands, not from the datapath's own wire
   dest_select_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ex && op_q == rsa_rotate_right_carry_op && !dest_q |=>
      acc_q == {$past(c_q), $past(regs_q[raddr_q][7:1])})
      else $error("rotate to accumulator wrong");
   dest_reg_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ex && dest_q && op_q == rsa_subtract_borrow_register_op |=> acc_q == $past(acc_q)
      && regs_q[$past(raddr_q)] == 8'($past(regs_q[raddr_q]) + ~$past(acc_q) + 8'($past(c_q))))
      else $error("register result misplaced");
   sub_reg_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ex && op_q == rsa_subtract_borrow_register_op && !dest_q |=>
      acc_q == 8'($past(regs_q[raddr_q]) + ~$past(acc_q) + 8'($past(c_q))))
      else $error("register subtract wrong");
   borrow_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
      sub_op |=> c_q == ($past(a_in) + {1'b0, ~$past(acc_q)} + 9'($past(c_q)) > 9'h0ff)
      && z_q == (8'($past(a_in) + ~$past(acc_q) + 8'($past(c_q))) == 8'h00))
      else $error("carry or zero wrong");
   sub_imm_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ex && op_q == rsa_subtract_borrow_immediate_op |=>
      acc_q == 8'($past(imm_q) + ~$past(acc_q) + 8'($past(c_q))))
      else $error("immediate subtract wrong");
   spr_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ex && op_q == rsa_special_page_read_op |=> acc_q == $past(spr_q[sidx_q])
      && {z_q, dc_q, c_q} == $past({z_q, dc_q, c_q})) else $error("special read wrong");
   digit_carry_a: assert property (@(posedge mclk) disable iff (!rst_b)
      sub_op |=> dc_q == ({1'b0, $past(a_in[3:0])} + {1'b0, ~$past(acc_q[3:0])}
      + 5'($past(c_q)) > 5'h0f)) else $error("digit carry wrong");
   bus_ack_a: assert property (@(posedge mclk) disable iff (!rst_b)
      req && !ack_q |=> !waitrequest || !req) else $error("bus answer late");
   cover_rot: cover property (@(posedge mclk) ex && op_q == rsa_rotate_right_carry_op);
   cover_reg_sub: cover property (@(posedge mclk) ex && op_q == rsa_subtract_borrow_register_op && dest_q);
   cover_imm_zero: cover property (@(posedge mclk) ex && op_q == rsa_subtract_borrow_immediate_op && sum == 8'h00);
   cover_spr: cover property (@(posedge mclk) ex && op_q == rsa_special_page_read_op);
endmodule

// ---- bench/rsa_alu_tb.sv ----
/*
 Self-checking bench for rsa_alu: rotate, both subtract-with-borrow forms and
 special-page read, driven over Avalon-MM. Assumes the register map of rsa_pkg.
*/
module rsa_alu_tb import rsa_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_b, read, write, waitrequest, carry_flag, digit_carry_flag, zero_flag;
   logic [5:0] address;
   logic [31:0] writedata, readdata, rv;
   logic [3:0] byteenable;
   logic [7:0] accumulator;
   int err_count, n_tests, cyc;
   rsa_alu i_rsa_alu (.mclk(mclk), .rst_b(rst_b), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .accumulator(accumulator), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
      .zero_flag(zero_flag));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic close_out();
      $display("Counts: %0d compares, %0d mismatches", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Whole run needs about 210 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 4000) begin
         $display("[FAIL] %0t timeout", $time);
         err_count++;
         close_out();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] %0t value %h, expected %h", $time, got, exp);
         err_count++;
      end
   endtask
   task automatic chkf(input logic [2:0] exp);
      n_tests++;
      if ({zero_flag, digit_carry_flag, carry_flag} !== exp) begin
         $display("[FAIL] %0t flags zdc %b, expected %b", $time, {zero_flag, digit_carry_flag, carry_flag}, exp);
         err_count++;
      end
   endtask
   // Design state moves only by non-blocking updates, so right after an edge we still see the pre-edge values
   // One idle edge between requests keeps strobes from being driven twice in one step
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge mclk);
      address <= a;
      writedata <= d;
      byteenable <= be;
      read <= ~wr;
      write <= wr;
      do @(posedge mclk);
      while (waitrequest !== 1'b0);
      rv = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic setreg(input logic [5:0] a, input logic [7:0] v);
      bus(1'b1, OFS_SPR_BASE, {26'h0, a}, 4'h1);
      bus(1'b1, OFS_REG_WIN, {24'h0, v}, 4'hf);
   endtask
   task automatic getreg(input logic [5:0] a);
      bus(1'b1, OFS_SPR_BASE, {26'h0, a}, 4'h1);
      bus(1'b0, OFS_REG_WIN, 32'h0, 4'hf);
   endtask
   task automatic setup(input logic [7:0] a, input logic [2:0] f);
      bus(1'b1, OFS_ACC, {24'h0, a}, 4'hf);
      bus(1'b1, OFS_STATUS, {29'h0, f}, 4'hf);
   endtask
   // Results land at the completing edge; they are looked at as the next edge arrives
   task automatic run(input logic [1:0] op, input logic d, input logic [5:0] ra, input logic [3:0] si);
      bus(1'b1, OFS_CMD, {12'h0, si, 2'b00, ra, 5'h00, d, op}, 4'hf);
      @(posedge mclk);
   endtask
   function automatic logic [10:0] sbc(input logic [7:0] x, input logic [7:0] a, input logic c);
      logic [4:0] lo;
      logic [8:0] s;
      lo = {1'b0, x[3:0]} + {1'b0, ~a[3:0]} + {4'h0, c};
      s = {1'b0, x} + {1'b0, ~a} + {8'h00, c};
      return {s[7:0] == 8'h00, lo[4], s[8], s[7:0]};
   endfunction
   task automatic t_rotate();
      setreg(6'd63, 8'ha5);
      setup(8'h00, 3'h0);
      run(2'd0, 1'b1, 6'd63, 4'h0);
      chkf(3'b001);
      getreg(6'd63);
      chk(rv[7:0], 8'h52);
      setup(8'h00, 3'h7);
      run(2'd0, 1'b0, 6'd63, 4'h0);
      chk(accumulator, 8'ha9);
      chkf(3'b110);
      getreg(6'd63);
      chk(rv[7:0], 8'h52);
      $display("rotate test ended");
   endtask
   task automatic t_sub();
      logic [7:0] xs [4] = '{8'h05, 8'h05, 8'h06, 8'h06};
      logic [10:0] e;
      logic [7:0] a;
      logic d;
      for (int op = 1; op < 3; op++) begin
         for (int i = 0; i < 4; i++) begin
            a = xs[i] ^ 8'h03;
            d = (op == 1) && i[1];
            e = sbc(xs[i], a, i[0]);
            if (op == 1) setreg(6'd0, xs[i]);
            else bus(1'b1, OFS_IMM, {24'h0, xs[i]}, 4'hf);
            setup(a, {2'b00, i[0]});
            run(op[1:0], d, 6'd0, 4'h0);
            chkf(e[10:8]);
            if (d) begin
               getreg(6'd0);
               chk(rv[7:0], e[7:0]);
               chk(accumulator, a);
            end else begin
               chk(accumulator, e[7:0]);
            end
         end
      end
      $display("subtract test ended");
   endtask
   task automatic t_spr();
      // Data lane writes the entry the window pointed at before this access
      bus(1'b1, OFS_SPR_BASE, 32'h0000_000f, 4'h1);
      bus(1'b1, OFS_SPR_BASE, 32'h0000_5500, 4'h2);
      bus(1'b1, OFS_SPR_BASE, 32'h0000_0000, 4'h1);
      bus(1'b1, OFS_SPR_BASE, 32'h0000_aa00, 4'h2);
      setup(8'h11, 3'h5);
      run(2'd3, 1'b0, 6'd0, 4'hf);
      chk(accumulator, 8'h55);
      chkf(3'b101);
      run(2'd3, 1'b0, 6'd0, 4'h0);
      chk(accumulator, 8'haa);
      bus(1'b0, OFS_SPR_BASE, 32'h0, 4'hf);
      chk(rv[15:8], 8'haa);
      bus(1'b0, OFS_ACC, 32'h0, 4'hf);
      chk(rv[7:0], 8'haa);
      bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
      chk(rv[7:0], 8'h05);
      bus(1'b0, 6'h3c, 32'h0, 4'hf);
      chk(rv[7:0], 8'h00);
      $display("special page test ended");
   endtask
   initial begin
      rst_b = 1'b0;
      {read, write, address, writedata, byteenable} = '0;
      {err_count, n_tests, cyc} = '0;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      @(negedge mclk);
      chk(accumulator, ACC_RST);
      chkf(FLAGS_RST);
      t_rotate();
      t_sub();
      t_spr();
      close_out();
   end
endmodule
